// >>> fcd_pkg.sv
// constants, command codes and carrier types of the flash command host
// assumes a 16-bit parallel nor flash with active-low strobes outside
// ***********************************************
// ***********************************************
package fcd_pkg;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned DATA_W = 16;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
  localparam logic [11:0] QUERY_ADDR   = 12'h055;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_SECURE  = 8'h88;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_BYPASS  = 8'h20;
  localparam logic [7:0] CMD_ERASE   = 8'h80;
  localparam logic [7:0] CMD_CHIP    = 8'h10;
  localparam logic [7:0] CMD_SECTOR  = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME  = 8'h30;
  localparam logic [7:0] CMD_QUERY   = 8'h98;
  localparam logic [7:0] CMD_RESET   = 8'hf0;
  localparam logic [7:0] CMD_ZERO    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MAKER   = 22'h000000;
  localparam logic [ADDR_W-1:0] OFS_PART    = 22'h000001;
  localparam logic [ADDR_W-1:0] OFS_PROTECT = 22'h000002;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SUSPEND_MAX_US = 20;
  localparam int unsigned SUSPEND_CYC = SUSPEND_MAX_US * CLK_MHZ;
  localparam int unsigned STROBE_CYC = 8;  // strobe counter load; the strobe phase lasts 9 cycles, 90 ns
  localparam int unsigned CNT_W = 12;
  // user order codes
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_AUTOSEL_READ, OP_SECURE_ENTER, OP_SECURE_EXIT,
    OP_PROGRAM, OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_EXIT,
    OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_SUSPEND, OP_RESUME,
    OP_QUERY
  } fcd_op_t;
  typedef struct packed {
    fcd_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fcd_req_t;
  typedef struct packed {
    logic                isWrite;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fcd_cyc_t;
  typedef enum logic [2:0] {
    MD_READ, MD_AUTOSEL, MD_BYPASS, MD_WINDOW, MD_ERASING, MD_SUSP, MD_BUSY
  } fcd_mode_t;
endpackage

// >>> fcd_bus_cycle.sv
// one asynchronous bus cycle on the flash strobes
// assumes the flash holds read data valid before the read strobe rises
module fcd_bus_cycle (
  input  wire logic                       ref_clk,   // system clock
  input  wire logic                       rst_n,     // async reset
  input  wire logic                       start,     // begin a cycle
  input  wire fcd_pkg::fcd_cyc_t          cyc,       // cycle contents
  input  wire logic [fcd_pkg::DATA_W-1:0] dqIn,      // synchronised data
  output logic                            done,      // cycle finished pulse
  output logic [fcd_pkg::DATA_W-1:0]      rdData,    // captured read data
  output logic                            chipSel_n, // chip select
  output logic                            writeEn_n, // write strobe
  output logic                            outEn_n,   // output strobe
  output logic [fcd_pkg::ADDR_W-1:0]      addr,      // address pins
  output logic [fcd_pkg::DATA_W-1:0]      dqOut,     // data driven
  output logic                            dqOe       // data drive enable
);
  // ***********************************************
  // phase machine
  // ***********************************************
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fcd_ph_t;
  fcd_ph_t ph_reg, ph_next;
  logic [fcd_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic [fcd_pkg::DATA_W-1:0] rd_reg, rd_next;
  logic [fcd_pkg::ADDR_W-1:0] a_reg, a_next;
  logic [fcd_pkg::DATA_W-1:0] d_reg, d_next;
  logic done_reg, done_next;
  logic csN_reg, csN_next;
  logic weN_reg, weN_next;
  logic oeN_reg, oeN_next;
  logic drv_reg, drv_next;
  always_comb begin
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    a_next = a_reg;
    d_next = d_reg;
    done_next = 1'b0;
    unique case (ph_reg)
      PH_IDLE: if (start) begin
        a_next = cyc.addr;
        d_next = cyc.data;
        wr_next = cyc.isWrite;
        ph_next = PH_SETUP;
      end
      PH_SETUP: begin
        cnt_next = fcd_pkg::CNT_W'(fcd_pkg::STROBE_CYC);
        ph_next = PH_STROBE;
      end
      PH_STROBE: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          if (!wr_reg) rd_next = dqIn;
          ph_next = PH_HOLD;
        end
      end
      PH_HOLD: begin
        done_next = 1'b1;
        ph_next = PH_IDLE;
      end
    endcase
    // strobes registered from the next phase: no decode glitch on the pins
    csN_next = (ph_next == PH_IDLE);
    weN_next = !(ph_next == PH_STROBE && wr_next);
    oeN_next = !(ph_next == PH_STROBE && !wr_next);
    drv_next = wr_next && (ph_next != PH_IDLE);
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= PH_IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      rd_reg <= '0;
      a_reg <= '0;
      d_reg <= '0;
      done_reg <= 1'b0;
      csN_reg <= 1'b1;
      weN_reg <= 1'b1;
      oeN_reg <= 1'b1;
      drv_reg <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      a_reg <= a_next;
      d_reg <= d_next;
      done_reg <= done_next;
      csN_reg <= csN_next;
      weN_reg <= weN_next;
      oeN_reg <= oeN_next;
      drv_reg <= drv_next;
    end
  end
  // address set before the falling strobe, data held past the rising one
  assign chipSel_n = csN_reg;
  assign writeEn_n = weN_reg;
  assign outEn_n   = oeN_reg;
  assign dqOe      = drv_reg;
  assign addr      = a_reg;
  assign dqOut     = d_reg;
  assign rdData    = rd_reg;
  assign done      = done_reg;
endmodule

// >>> fcd_flash_host.sv
// flash command host: turns user orders into flash bus cycle sequences
// assumes one flash on the pins; ready/busy and data come in unsynchronised
module fcd_flash_host (
  input  wire logic                       ref_clk,     // 100 mhz clock
  input  wire logic                       rst_n,       // async reset
  input  wire logic                       reqValid,    // order strobe
  input  wire fcd_pkg::fcd_req_t          req,         // order
  output logic                            reqReady,    // order accepted
  output logic                            rspValid,    // order done pulse
  output logic                            rspRefused,  // order not legal now
  output logic [fcd_pkg::DATA_W-1:0]      rspData,     // read result
  output fcd_pkg::fcd_mode_t              mode,        // device mode tracked
  output logic                            chipSel_n,   // flash chip select
  output logic                            writeEn_n,   // flash write strobe
  output logic                            outEn_n,     // flash output strobe
  output logic [fcd_pkg::ADDR_W-1:0]      flashAddr,   // flash address
  output logic [fcd_pkg::DATA_W-1:0]      dqOut,       // flash data out
  output logic                            dqOe,        // flash data enable
  input  wire logic [fcd_pkg::DATA_W-1:0] dqIn,        // flash data in
  input  wire logic                       readyBusy_n  // ready_busy_n_output
);
  // ***********************************************
  // pin synchronisers
  // ***********************************************
  logic [fcd_pkg::DATA_W-1:0] dqS1_reg, dqS2_reg;
  logic rbS1_reg, rbS2_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqS1_reg <= '0;
      dqS2_reg <= '0;
      rbS1_reg <= 1'b0;
      rbS2_reg <= 1'b0;
    end else begin
      dqS1_reg <= dqIn;
      dqS2_reg <= dqS1_reg;
      rbS1_reg <= readyBusy_n;
      rbS2_reg <= rbS1_reg;
    end
  end

  // ***********************************************
  // sequence table
  // ***********************************************
  function automatic fcd_pkg::fcd_cyc_t wcyc(input logic [11:0] a, input logic [7:0] d);
    wcyc.isWrite = 1'b1;
    wcyc.addr = fcd_pkg::ADDR_W'(a);
    wcyc.data = fcd_pkg::DATA_W'(d);
  endfunction
  function automatic logic [2:0] seqLen(input fcd_pkg::fcd_op_t op);
    unique case (op)
      fcd_pkg::OP_READ, fcd_pkg::OP_RESET, fcd_pkg::OP_SECTOR_ADD,
      fcd_pkg::OP_SUSPEND, fcd_pkg::OP_RESUME, fcd_pkg::OP_QUERY: seqLen = 3'd1;
      fcd_pkg::OP_BYPASS_PROGRAM, fcd_pkg::OP_BYPASS_EXIT: seqLen = 3'd2;
      fcd_pkg::OP_SECURE_ENTER, fcd_pkg::OP_BYPASS_ENTER: seqLen = 3'd3;
      fcd_pkg::OP_AUTOSEL_READ, fcd_pkg::OP_SECURE_EXIT,
      fcd_pkg::OP_PROGRAM: seqLen = 3'd4;
      default: seqLen = 3'd6;
    endcase
  endfunction
  // cycle k of the sequence for order r
  function automatic fcd_pkg::fcd_cyc_t seqCyc(input fcd_pkg::fcd_req_t r,
                                               input logic [2:0] k);
    fcd_pkg::fcd_cyc_t c;
    c = wcyc(fcd_pkg::UNLOCK_ADDR1, fcd_pkg::CMD_UNLOCK1);
    unique case (r.op)
      fcd_pkg::OP_READ: c = '{isWrite: 1'b0, addr: r.addr, data: '0};
      fcd_pkg::OP_RESET: c = wcyc('0, fcd_pkg::CMD_RESET);
      fcd_pkg::OP_SECTOR_ADD: c = '{isWrite: 1'b1, addr: r.addr,
                                    data: fcd_pkg::DATA_W'(fcd_pkg::CMD_SECTOR)};
      fcd_pkg::OP_SUSPEND: c = wcyc('0, fcd_pkg::CMD_SUSPEND);
      fcd_pkg::OP_RESUME: c = wcyc('0, fcd_pkg::CMD_RESUME);
      fcd_pkg::OP_QUERY: c = wcyc(fcd_pkg::QUERY_ADDR, fcd_pkg::CMD_QUERY);
      fcd_pkg::OP_BYPASS_PROGRAM: c = (k == 3'd0) ? wcyc('0, fcd_pkg::CMD_PROGRAM)
                               : '{isWrite: 1'b1, addr: r.addr, data: r.data};
      fcd_pkg::OP_BYPASS_EXIT: c = wcyc('0, (k == 3'd0) ? fcd_pkg::CMD_AUTOSEL
                                                       : fcd_pkg::CMD_ZERO);
      default: begin
        // unlock prefix on cycles 0,1; second prefix 3,4 only in six-cycle erases
        if (k == 3'd1 || (k == 3'd4 && seqLen(r.op) == 3'd6))
          c = wcyc(fcd_pkg::UNLOCK_ADDR2, fcd_pkg::CMD_UNLOCK2);
        else if (k == 3'd0 || (k == 3'd3 && seqLen(r.op) == 3'd6))
          c = wcyc(fcd_pkg::UNLOCK_ADDR1, fcd_pkg::CMD_UNLOCK1);
        else if (k == 3'd2) begin
          unique case (r.op)
            fcd_pkg::OP_AUTOSEL_READ, fcd_pkg::OP_SECURE_EXIT:
              c = wcyc(fcd_pkg::UNLOCK_ADDR1, fcd_pkg::CMD_AUTOSEL);
            fcd_pkg::OP_SECURE_ENTER: c = wcyc(fcd_pkg::UNLOCK_ADDR1, fcd_pkg::CMD_SECURE);
            fcd_pkg::OP_PROGRAM: c = wcyc(fcd_pkg::UNLOCK_ADDR1, fcd_pkg::CMD_PROGRAM);
            fcd_pkg::OP_BYPASS_ENTER:
              c = wcyc(fcd_pkg::UNLOCK_ADDR1, fcd_pkg::CMD_BYPASS);
            default: c = wcyc(fcd_pkg::UNLOCK_ADDR1, fcd_pkg::CMD_ERASE);
          endcase
        end else if (r.op == fcd_pkg::OP_AUTOSEL_READ)
          c = '{isWrite: 1'b0, addr: r.addr, data: '0};
        else if (r.op == fcd_pkg::OP_SECURE_EXIT) c = wcyc('0, fcd_pkg::CMD_ZERO);
        else if (r.op == fcd_pkg::OP_PROGRAM)
          c = '{isWrite: 1'b1, addr: r.addr, data: r.data};
        else if (r.op == fcd_pkg::OP_CHIP_ERASE)
          c = wcyc(fcd_pkg::UNLOCK_ADDR1, fcd_pkg::CMD_CHIP);
        else c = '{isWrite: 1'b1, addr: r.addr,
                   data: fcd_pkg::DATA_W'(fcd_pkg::CMD_SECTOR)};
      end
    endcase
    return c;
  endfunction
  // legality of an order in the tracked mode
  function automatic logic allowed(input fcd_pkg::fcd_op_t op, input fcd_pkg::fcd_mode_t m);
    unique case (m)
      fcd_pkg::MD_BUSY, fcd_pkg::MD_ERASING:
        allowed = (op == fcd_pkg::OP_SUSPEND && m == fcd_pkg::MD_ERASING)
               || op == fcd_pkg::OP_READ;
      fcd_pkg::MD_WINDOW: allowed = op != fcd_pkg::OP_RESUME;
      fcd_pkg::MD_BYPASS: allowed = op == fcd_pkg::OP_BYPASS_PROGRAM
                                 || op == fcd_pkg::OP_BYPASS_EXIT || op == fcd_pkg::OP_READ;
      fcd_pkg::MD_SUSP: allowed = op == fcd_pkg::OP_READ || op == fcd_pkg::OP_PROGRAM
                       || op == fcd_pkg::OP_AUTOSEL_READ || op == fcd_pkg::OP_RESET
                       || op == fcd_pkg::OP_RESUME;
      fcd_pkg::MD_AUTOSEL: allowed = op != fcd_pkg::OP_SUSPEND && op != fcd_pkg::OP_RESUME
                                  && op != fcd_pkg::OP_BYPASS_PROGRAM
                                  && op != fcd_pkg::OP_BYPASS_EXIT && op != fcd_pkg::OP_SECTOR_ADD;
      default: allowed = op != fcd_pkg::OP_SUSPEND && op != fcd_pkg::OP_RESUME
                      && op != fcd_pkg::OP_BYPASS_PROGRAM
                      && op != fcd_pkg::OP_BYPASS_EXIT && op != fcd_pkg::OP_SECTOR_ADD;
    endcase
  endfunction

  // ***********************************************
  // order sequencer
  // ***********************************************
  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DELAY, ST_BUSY} fcd_st_t;
  fcd_st_t st_reg, st_next;
  fcd_pkg::fcd_req_t r_reg, r_next;
  fcd_pkg::fcd_mode_t mode_reg, mode_next;
  logic susp_reg, susp_next;  // an erase is suspended underneath
  logic [2:0] k_reg, k_next;
  logic [fcd_pkg::CNT_W-1:0] dly_reg, dly_next;
  logic rdy_reg, rdy_next;
  logic rv_reg, rv_next;
  logic ref_reg, ref_next;
  logic [fcd_pkg::DATA_W-1:0] rd_reg, rd_next;
  logic cycStart, cycDone;
  logic [fcd_pkg::DATA_W-1:0] cycData;
  assign cycStart = (st_reg == ST_ISSUE);
  always_comb begin
    st_next = st_reg;
    r_next = r_reg;
    mode_next = mode_reg;
    susp_next = susp_reg;
    k_next = k_reg;
    dly_next = dly_reg;
    rdy_next = 1'b0;
    rv_next = 1'b0;
    ref_next = 1'b0;
    rd_next = rd_reg;
    unique case (st_reg)
      ST_IDLE: if (reqValid && !rdy_reg) begin
        rdy_next = 1'b1;
        if (allowed(req.op, mode_reg)) begin
          r_next = req;
          k_next = '0;
          st_next = ST_ISSUE;
        end else begin
          rv_next = 1'b1;
          ref_next = 1'b1;
        end
      end
      ST_ISSUE: st_next = ST_WAIT;
      ST_WAIT: if (cycDone) begin
        rd_next = cycData;
        if (k_reg + 3'd1 < seqLen(r_reg.op)) begin
          k_next = k_reg + 3'd1;
          st_next = ST_ISSUE;
        end else begin
          st_next = ST_IDLE;
          rv_next = 1'b1;
          unique case (r_reg.op)
            fcd_pkg::OP_PROGRAM, fcd_pkg::OP_BYPASS_PROGRAM, fcd_pkg::OP_CHIP_ERASE: begin
              st_next = ST_BUSY;
              rv_next = 1'b0;
              mode_next = fcd_pkg::MD_BUSY;
            end
            fcd_pkg::OP_SECTOR_ERASE, fcd_pkg::OP_SECTOR_ADD: mode_next = fcd_pkg::MD_WINDOW;
            fcd_pkg::OP_SUSPEND: begin
              susp_next = 1'b1;
              mode_next = fcd_pkg::MD_SUSP;
              if (mode_reg == fcd_pkg::MD_ERASING) begin
                st_next = ST_DELAY;
                rv_next = 1'b0;
                dly_next = fcd_pkg::CNT_W'(fcd_pkg::SUSPEND_CYC);
              end
            end
            fcd_pkg::OP_RESUME: begin
              susp_next = 1'b0;
              mode_next = fcd_pkg::MD_ERASING;
            end
            fcd_pkg::OP_AUTOSEL_READ: mode_next = fcd_pkg::MD_AUTOSEL;
            fcd_pkg::OP_RESET: mode_next = susp_reg ? fcd_pkg::MD_SUSP : fcd_pkg::MD_READ;
            fcd_pkg::OP_BYPASS_ENTER: mode_next = fcd_pkg::MD_BYPASS;
            fcd_pkg::OP_BYPASS_EXIT: mode_next = fcd_pkg::MD_READ;
            fcd_pkg::OP_READ: if (mode_reg == fcd_pkg::MD_WINDOW) mode_next = fcd_pkg::MD_ERASING;
            default: if (mode_reg == fcd_pkg::MD_WINDOW)
              mode_next = fcd_pkg::MD_READ;
          endcase
        end
      end
      ST_DELAY: begin
        dly_next = dly_reg - 1'b1;
        if (dly_reg == '0) begin
          st_next = ST_IDLE;
          rv_next = 1'b1;
        end
      end
      ST_BUSY: if (rbS2_reg) begin
        st_next = ST_IDLE;
        rv_next = 1'b1;
        if (r_reg.op == fcd_pkg::OP_BYPASS_PROGRAM) mode_next = fcd_pkg::MD_BYPASS;
        else mode_next = susp_reg ? fcd_pkg::MD_SUSP : fcd_pkg::MD_READ;
      end
      default: st_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      r_reg <= '0;
      mode_reg <= fcd_pkg::MD_READ;
      susp_reg <= 1'b0;
      k_reg <= '0;
      dly_reg <= '0;
      rdy_reg <= 1'b0;
      rv_reg <= 1'b0;
      ref_reg <= 1'b0;
      rd_reg <= '0;
    end else begin
      st_reg <= st_next;
      r_reg <= r_next;
      mode_reg <= mode_next;
      susp_reg <= susp_next;
      k_reg <= k_next;
      dly_reg <= dly_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      ref_reg <= ref_next;
      rd_reg <= rd_next;
    end
  end
  assign reqReady = rdy_reg;
  assign rspValid = rv_reg;
  assign rspRefused = ref_reg;
  assign rspData = rd_reg;
  assign mode = mode_reg;

  // ***********************************************
  // bus cycle engine
  // ***********************************************
  fcd_bus_cycle u_cyc (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (cycStart),
    .cyc       (seqCyc(r_reg, k_reg)),
    .dqIn      (dqS2_reg),
    .done      (cycDone),
    .rdData    (cycData),
    .chipSel_n (chipSel_n),
    .writeEn_n (writeEn_n),
    .outEn_n   (outEn_n),
    .addr      (flashAddr),
    .dqOut     (dqOut),
    .dqOe      (dqOe)
  );

  // ***********************************************
  // checks
  // ***********************************************
  a_suspend_legal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_reg == ST_IDLE && reqValid && !rdy_reg && req.op == fcd_pkg::OP_SUSPEND
     && mode_reg != fcd_pkg::MD_ERASING && mode_reg != fcd_pkg::MD_WINDOW) |=> rspRefused)
    else $error("suspend accepted outside sector erase");
  a_busy_no_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_reg == ST_BUSY |-> !cycStart && chipSel_n && writeEn_n)
    else $error("command issued while program runs");
  a_resume_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rv_reg && !ref_reg && r_reg.op == fcd_pkg::OP_RESUME) |-> mode_reg == fcd_pkg::MD_ERASING)
    else $error("resume did not restart erase");
  a_reset_susp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rv_reg && !ref_reg && r_reg.op == fcd_pkg::OP_RESET && susp_reg) |-> mode_reg == fcd_pkg::MD_SUSP)
    else $error("reset left suspend-read mode");
  a_bypass_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_reg == fcd_pkg::MD_BYPASS && st_reg == ST_IDLE && reqValid && !rdy_reg
     && req.op == fcd_pkg::OP_PROGRAM) |=> rspRefused)
    else $error("full program sent in bypass mode");
endmodule

// >>> fcd_flash_model.sv
// behavioural nor flash: command decoder, busy line and read data
// assumes the host holds address and data steady around each strobe
module fcd_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00c3, // arbitrary value
  parameter logic [15:0] PART_ID  = 16'h0c3c  // arbitrary value
) (
  input  wire logic        chipSel_n,   // chip select
  input  wire logic        writeEn_n,   // write strobe
  input  wire logic        outEn_n,     // output strobe
  input  wire logic [21:0] flashAddr,   // address
  input  wire logic [15:0] dqOut,       // host data
  output logic      [15:0] dqIn,        // device data
  output logic             readyBusy_n  // ready_busy_n_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [21:0] la, sect;
  logic [15:0] lastQ, q;
  logic        auto, byp, ers, susp, erasing, progBusy;
  int          st;
  event        progEv, chipEv;
  wire  [7:0]  d = dqOut[7:0];
  wire  [11:0] a = flashAddr[11:0];
  initial begin
    {auto, byp, ers, susp, erasing, progBusy, la, sect, lastQ} = '0;
    st = 0;
  end
  assign readyBusy_n = !(progBusy || (erasing && !susp));
  always @(negedge writeEn_n) if (!chipSel_n) la = flashAddr;
  // ***************
  // write decoding
  // ***************
  always @(posedge writeEn_n) if (!chipSel_n) begin
    if (erasing && !susp) susp = (d == 8'hb0);
    else if (progBusy) st = st;
    else if (st == 4) begin
      st = 0;
      -> progEv;
    end
    else if (d == 8'hf0) {auto, st} = '0;
    else if (susp && st == 0 && d == 8'h30) susp = 1'b0;
    else if (byp && st == 6) begin
      byp = (d != 8'h00);
      st = 0;
    end
    else if (byp) st = (d == 8'ha0) ? 4 : (d == 8'h90) ? 6 : 0;
    else if (st == 0) st = (d == 8'haa && a == 12'h555) ? 1 : 0;
    else if (st == 1) st = (d == 8'h55 && a == 12'h2aa) ? 2 : 0;
    else begin
      st = 0;
      case (d)
        8'h90: auto = 1'b1;
        8'ha0: st = 4;
        8'h20: byp = 1'b1;
        8'h80: ers = 1'b1;
        8'h10: if (ers) -> chipEv;
        8'h30: if (ers) {erasing, sect} = {1'b1, la};
        default: st = 0;
      endcase
      if (d != 8'h80) ers = 1'b0;
    end
  end
  always @(progEv) begin
    progBusy = 1'b1;
    #500 progBusy = 1'b0;
  end
  always @(chipEv) begin
    progBusy = 1'b1;
    #2000 progBusy = 1'b0;
  end
  // released bus shows the inverse of the last word
  assign q = auto ? (a == 12'h000 ? MAKER_ID : a == 12'h001 ? PART_ID : 16'h0000)
           : (susp && flashAddr[21:15] == sect[21:15]) ? 16'h0080
           : flashAddr[15:0] ^ 16'h5a5a;
  always @(posedge outEn_n) lastQ = q;
  assign dqIn = (!outEn_n && !chipSel_n) ? q : ~lastQ;
endmodule

// >>> flash_command_decoder_erase_suspend_bench.sv
// testbench of the flash command host against the flash model
// assumes fcd_pkg, fcd_flash_host and fcd_flash_model are compiled first
module flash_command_decoder_erase_suspend_bench;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
  localparam logic [15:0] MAKER = 16'h00c3; // arbitrary value
  logic ref_clk, rst_n, reqValid, reqReady, rspValid, rspRefused;
  logic chipSel_n, writeEn_n, outEn_n, dqOe, readyBusy_n;
  logic [21:0] flashAddr;
  logic [15:0] rspData, dqOut, dqIn;
  fcd_pkg::fcd_req_t  req;
  fcd_pkg::fcd_mode_t mode;
  int n_mismatch, tests_run;
  fcd_flash_host dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid(rspValid), .rspRefused(rspRefused), .rspData(rspData),
    .mode(mode), .chipSel_n(chipSel_n), .writeEn_n(writeEn_n), .outEn_n(outEn_n),
    .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .readyBusy_n(readyBusy_n));
  fcd_flash_model #(.MAKER_ID(MAKER)) flash_u (.chipSel_n(chipSel_n), .writeEn_n(writeEn_n),
    .outEn_n(outEn_n), .flashAddr(flashAddr), .dqOut(dqOut), .dqIn(dqIn),
    .readyBusy_n(readyBusy_n));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge writeEn_n) if (rst_n && !chipSel_n) `CHK("drive", dqOe, 1'b1)
  always @(negedge outEn_n) if (rst_n) `CHK("release", dqOe, 1'b0)
  task automatic order(input fcd_pkg::fcd_op_t op, input logic [21:0] a, input logic [15:0] d,
                       input logic refd, input fcd_pkg::fcd_mode_t md);
    int n;
    n = 0;
    req = '{op, a, d};
    reqValid = 1'b1;
    do begin @(posedge ref_clk); #1; n++; end while (reqReady !== 1'b1 && n < 20);
    reqValid = 1'b0;
    `CHK("taken", reqReady, 1'b1)
    `CHK("refused", rspRefused, refd)
    while (rspValid !== 1'b1 && n < 9000) begin @(posedge ref_clk); #1; n++; end
    `CHK("finished", rspValid, 1'b1)
    @(posedge ref_clk);
    #1;
    `CHK("mode", mode, md)
  endtask
  task automatic t_autosel;
    order(fcd_pkg::OP_QUERY, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_READ);
    order(fcd_pkg::OP_SECURE_ENTER, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_READ);
    order(fcd_pkg::OP_SECURE_EXIT, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_READ);
    order(fcd_pkg::OP_AUTOSEL_READ, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_AUTOSEL);
    `CHK("maker", rspData, MAKER)
    order(fcd_pkg::OP_RESET, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_READ);
    order(fcd_pkg::OP_SUSPEND, 22'h0, 16'h0, 1'b1, fcd_pkg::MD_READ);
    order(fcd_pkg::OP_RESUME, 22'h0, 16'h0, 1'b1, fcd_pkg::MD_READ);
  endtask
  task automatic t_bypass;
    order(fcd_pkg::OP_BYPASS_ENTER, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_BYPASS);
    order(fcd_pkg::OP_PROGRAM, 22'h100, 16'h1234, 1'b1, fcd_pkg::MD_BYPASS);
    order(fcd_pkg::OP_BYPASS_PROGRAM, 22'h100, 16'h1234, 1'b0, fcd_pkg::MD_BYPASS);
    order(fcd_pkg::OP_BYPASS_EXIT, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_READ);
    order(fcd_pkg::OP_CHIP_ERASE, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_READ);
  endtask
  task automatic t_suspend;
    order(fcd_pkg::OP_SECTOR_ERASE, 22'h010000, 16'h0, 1'b0, fcd_pkg::MD_WINDOW);
    order(fcd_pkg::OP_SECTOR_ADD, 22'h018000, 16'h0, 1'b0, fcd_pkg::MD_WINDOW);
    order(fcd_pkg::OP_SUSPEND, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_SUSP);
    order(fcd_pkg::OP_READ, 22'h010004, 16'h0, 1'b0, fcd_pkg::MD_SUSP);
    `CHK("status", rspData[7:0], 8'h80)
    order(fcd_pkg::OP_READ, 22'h200004, 16'h0, 1'b0, fcd_pkg::MD_SUSP);
    `CHK("array", rspData, 16'h5a5e)
    order(fcd_pkg::OP_PROGRAM, 22'h200008, 16'h00ff, 1'b0, fcd_pkg::MD_SUSP);
    order(fcd_pkg::OP_AUTOSEL_READ, 22'h2, 16'h0, 1'b0, fcd_pkg::MD_AUTOSEL);
    `CHK("protect", rspData[7:0], 8'h00)
    order(fcd_pkg::OP_RESET, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_SUSP);
    order(fcd_pkg::OP_QUERY, 22'h0, 16'h0, 1'b1, fcd_pkg::MD_SUSP);
    order(fcd_pkg::OP_RESUME, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_ERASING);
    order(fcd_pkg::OP_RESUME, 22'h0, 16'h0, 1'b1, fcd_pkg::MD_ERASING);
    order(fcd_pkg::OP_SUSPEND, 22'h0, 16'h0, 1'b0, fcd_pkg::MD_SUSP);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200_000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_n, reqValid, n_mismatch, tests_run} = '0;
    req = '0;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_autosel();
    t_bypass();
    t_suspend();
    end_of_test();
  end
endmodule
